/* verilog/sdpc_map.vh */
// register offsets, field positions, reset values and command codes of the sdram pin interface
`ifndef SDPC_MAP_VH
`define SDPC_MAP_VH

// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define SDPC_OFS_CTRL      12'h000
`define SDPC_OFS_STATUS    12'h004
`define SDPC_OFS_MODE      12'h008
`define SDPC_OFS_ROW0      12'h00C
`define SDPC_OFS_ROW1      12'h010

// -------------------------------------------------------------
// fields and reset values
// -------------------------------------------------------------
`define SDPC_CTRL_CMD_EN   0
`define SDPC_CTRL_RESET    1'b1
`define SDPC_MODE_RESET    12'h030
`define SDPC_MODE_BL_LSB   0
`define SDPC_MODE_BT_BIT   3
`define SDPC_MODE_CL_LSB   4
`define SDPC_MODE_WB_BIT   9
`define SDPC_CL_TWO        3'h2

// -------------------------------------------------------------
// command codes {row strobe, column strobe, write enable}
// -------------------------------------------------------------
`define SDPC_CMD_MRS       3'h0
`define SDPC_CMD_REF       3'h1
`define SDPC_CMD_PRE       3'h2
`define SDPC_CMD_ACT       3'h3
`define SDPC_CMD_WR        3'h4
`define SDPC_CMD_RD        3'h5
`define SDPC_CMD_BST       3'h6
`define SDPC_CMD_NOP       3'h7

// -------------------------------------------------------------
// address pin fields
// -------------------------------------------------------------
`define SDPC_A_AP_BIT      10
`define SDPC_A_BANK_BIT    11

`endif

/* verilog/sdpc_core.v */
// device side command, address and data interface of a two-bank 16-bit sdram
//
// Functional notes
// - activate takes row from address bits 0-10
// - read or write takes column from bits 0-7
// - precharge: bit 10 low one bank, high both
// - bit 10 on access auto-precharges after burst
// - mode set loads code from all address bits
// - bank bit low bank zero, high bank one
// - command decoded from three strobes together
// - edges ignored while clock gate input low
// - gate low means power-down, suspend or self refresh
// - all inputs on rising edge, gate asynchronous
// - chip select high ignores commands, running burst continues
// - write byte stored only while mask low
// - low mask bits 0-7, high mask bits 8-15
// - read latency two or three clocks
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_map.vh"

module sdpc_core (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        cs_n,
	input  wire        ras_n,
	input  wire        cas_n,
	input  wire        we_n,
	input  wire [11:0] addr,
	input  wire        cke,
	input  wire        low_byte_mask,
	input  wire        high_byte_mask,
	input  wire [15:0] dq_in,
	output reg  [15:0] dq_out,
	output reg  [1:0]  dq_oe
);

	localparam [3:0] ST_ACT = 4'h1;
	localparam [3:0] ST_PDN = 4'h2;
	localparam [3:0] ST_SUS = 4'h4;
	localparam [3:0] ST_SRF = 4'h8;

	// -------------------------------------------------------------
	// helper functions
	// -------------------------------------------------------------
	function [8:0] burst_len;
		input [2:0] code;
		begin
			case (code)
				3'h0: burst_len = 9'h001;
				3'h1: burst_len = 9'h002;
				3'h2: burst_len = 9'h004;
				3'h3: burst_len = 9'h008;
				default: burst_len = 9'h100;
			endcase
		end
	endfunction

	function [7:0] beat_col;
		input [7:0] start;
		input [8:0] cnt;
		input [8:0] len;
		input       ilv;
		reg   [7:0] msk;
		begin
			msk = len[7:0] - 8'h01;
			if (ilv)
				beat_col = start ^ (cnt[7:0] & msk);
			else
				beat_col = (start & ~msk) | ((start + cnt[7:0]) & msk);
		end
	endfunction

	function [8:0] mem_idx;
		input       bank;
		input [7:0] col;
		begin
			mem_idx = {bank, col};
		end
	endfunction

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	reg  [15:0] mem [0:511];
	reg         cke_s1_reg, cke_s2_reg, cke_s3_reg, cke_lvl_reg;
	reg  [3:0]  pwr_reg;
	reg         ctrl_en_reg;
	reg  [11:0] mode_reg;
	reg  [10:0] row0_reg, row1_reg;
	reg         open0_reg, open1_reg;
	reg         last_ref_reg;
	reg         bact_reg, bwr_reg, bap_reg, bbank_reg;
	reg  [7:0]  bstart_reg;
	reg  [8:0]  bcnt_reg, blen_reg;
	reg         p0_v_reg, p1_v_reg;
	reg  [1:0]  p0_oe_reg, p1_oe_reg;
	reg  [15:0] p0_d_reg, p1_d_reg;

	wire        dev_en  = ce & cke_lvl_reg;
	wire        cmd_ok  = dev_en & ~cs_n & ctrl_en_reg;
	wire [2:0]  cmd     = {ras_n, cas_n, we_n};
	wire        c_act   = cmd_ok & (cmd == `SDPC_CMD_ACT);
	wire        c_rd    = cmd_ok & (cmd == `SDPC_CMD_RD);
	wire        c_wr    = cmd_ok & (cmd == `SDPC_CMD_WR);
	wire        c_pre   = cmd_ok & (cmd == `SDPC_CMD_PRE);
	wire        c_ref   = cmd_ok & (cmd == `SDPC_CMD_REF);
	wire        c_mrs   = cmd_ok & (cmd == `SDPC_CMD_MRS);
	wire        c_bst   = cmd_ok & (cmd == `SDPC_CMD_BST);
	wire        c_new   = c_rd | c_wr;
	wire        a_bank  = addr[`SDPC_A_BANK_BIT];
	wire        a_ap    = addr[`SDPC_A_AP_BIT];
	wire        ilv     = mode_reg[`SDPC_MODE_BT_BIT];
	wire [8:0]  new_len = (c_wr & mode_reg[`SDPC_MODE_WB_BIT]) ? 9'h001 :
			burst_len(mode_reg[`SDPC_MODE_BL_LSB +: 3]);
	wire        cont    = dev_en & bact_reg & ~c_new & ~c_bst;

	// one beat per valid edge: the new access or the running burst
	wire        beat_v  = c_new | cont;
	wire        beat_w  = c_new ? c_wr : bwr_reg;
	wire        beat_b  = c_new ? a_bank : bbank_reg;
	wire [7:0]  beat_c  = c_new ? addr[7:0] :
			beat_col(bstart_reg, bcnt_reg, blen_reg, ilv);
	wire        last    = c_new ? (new_len == 9'h001) : (bcnt_reg == blen_reg - 9'h001);
	wire        ap_now  = beat_v & last & (c_new ? a_ap : bap_reg);
	wire [8:0]  beat_i  = mem_idx(beat_b, beat_c);
	wire        cke_chg = (cke_s2_reg == cke_s3_reg) & (cke_s3_reg != cke_lvl_reg);

	// -------------------------------------------------------------
	// clock gate input synchroniser and power states
	// -------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cke_s1_reg  <= 1'b0;
			cke_s2_reg  <= 1'b0;
			cke_s3_reg  <= 1'b0;
			cke_lvl_reg <= 1'b0;
			pwr_reg     <= ST_PDN;
		end else if (ce) begin
			cke_s1_reg <= cke;
			cke_s2_reg <= cke_s1_reg;
			cke_s3_reg <= cke_s2_reg;
			if (cke_chg) begin
				cke_lvl_reg <= cke_s3_reg;
				case (pwr_reg)
					ST_ACT: begin
						if (bact_reg)
							pwr_reg <= ST_SUS;
						else if (last_ref_reg)
							pwr_reg <= ST_SRF;
						else
							pwr_reg <= ST_PDN;
					end
					default: pwr_reg <= ST_ACT;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// command decode: banks, rows, mode, bursts
	// -------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg     <= `SDPC_MODE_RESET;
			row0_reg     <= 11'h000;
			row1_reg     <= 11'h000;
			open0_reg    <= 1'b0;
			open1_reg    <= 1'b0;
			last_ref_reg <= 1'b0;
			bact_reg     <= 1'b0;
			bwr_reg      <= 1'b0;
			bap_reg      <= 1'b0;
			bbank_reg    <= 1'b0;
			bstart_reg   <= 8'h00;
			bcnt_reg     <= 9'h000;
			blen_reg     <= 9'h001;
		end else if (dev_en) begin
			if (cmd_ok && cmd != `SDPC_CMD_NOP)
				last_ref_reg <= c_ref;
			if (c_mrs)
				mode_reg <= addr;
			if (c_act) begin
				if (a_bank) begin
					row1_reg  <= addr[10:0];
					open1_reg <= 1'b1;
				end else begin
					row0_reg  <= addr[10:0];
					open0_reg <= 1'b1;
				end
			end
			if (c_pre) begin
				if (a_ap || !a_bank)
					open0_reg <= 1'b0;
				if (a_ap || a_bank)
					open1_reg <= 1'b0;
			end
			if (ap_now) begin
				if (beat_b)
					open1_reg <= 1'b0;
				else
					open0_reg <= 1'b0;
			end
			if (c_new) begin
				bact_reg   <= ~last;
				bwr_reg    <= c_wr;
				bap_reg    <= a_ap;
				bbank_reg  <= a_bank;
				bstart_reg <= addr[7:0];
				bcnt_reg   <= 9'h001;
				blen_reg   <= new_len;
			end else if (c_bst || c_pre || (cont && last)) begin
				bact_reg <= 1'b0;
			end else if (cont) begin
				bcnt_reg <= bcnt_reg + 9'h001;
			end
		end
	end

	// -------------------------------------------------------------
	// storage with byte masks
	// -------------------------------------------------------------
	always @(posedge pclk) begin
		if (dev_en && beat_v && beat_w) begin
			if (!low_byte_mask)
				mem[beat_i][7:0] <= dq_in[7:0];
			if (!high_byte_mask)
				mem[beat_i][15:8] <= dq_in[15:8];
		end
	end

	// -------------------------------------------------------------
	// read pipeline and data drivers
	// -------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p0_v_reg  <= 1'b0;
			p1_v_reg  <= 1'b0;
			p0_oe_reg <= 2'h0;
			p1_oe_reg <= 2'h0;
			p0_d_reg  <= 16'h0000;
			p1_d_reg  <= 16'h0000;
			dq_out    <= 16'h0000;
			dq_oe     <= 2'h0;
		end else if (dev_en) begin
			p0_v_reg  <= beat_v & ~beat_w;
			p0_oe_reg <= {~high_byte_mask, ~low_byte_mask};
			p0_d_reg  <= mem[beat_i];
			p1_v_reg  <= p0_v_reg;
			p1_oe_reg <= p0_oe_reg;
			p1_d_reg  <= p0_d_reg;
			if (mode_reg[`SDPC_MODE_CL_LSB +: 3] == `SDPC_CL_TWO) begin
				dq_out <= p0_d_reg;
				dq_oe  <= p0_v_reg ? p0_oe_reg : 2'h0;
			end else begin
				dq_out <= p1_d_reg;
				dq_oe  <= p1_v_reg ? p1_oe_reg : 2'h0;
			end
		end
	end

	// -------------------------------------------------------------
	// apb register slave
	// -------------------------------------------------------------
	reg  [31:0] rd_mux;
	reg         rd_hit;

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			`SDPC_OFS_CTRL:   rd_mux = {31'h0, ctrl_en_reg};
			`SDPC_OFS_STATUS: rd_mux = {24'h0, cke_lvl_reg, open1_reg, open0_reg,
					bact_reg, pwr_reg};
			`SDPC_OFS_MODE:   rd_mux = {20'h0, mode_reg};
			`SDPC_OFS_ROW0:   rd_mux = {21'h0, row0_reg};
			`SDPC_OFS_ROW1:   rd_mux = {21'h0, row1_reg};
			default:          rd_hit = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			prdata      <= 32'h0000_0000;
			ctrl_en_reg <= `SDPC_CTRL_RESET;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~rd_hit;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
			if (psel && penable && pready && pwrite && paddr == `SDPC_OFS_CTRL)
				ctrl_en_reg <= pwdata[`SDPC_CTRL_CMD_EN];
		end
	end

endmodule // sdpc_core

`default_nettype wire

/* dv/sdpc_core_assertions.sv */
// concurrent checks on the ports of the sdram pin interface
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_map.vh"
module sdpc_core_assertions (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        cs_n,
	input wire        ras_n,
	input wire        cas_n,
	input wire        we_n,
	input wire        low_byte_mask,
	input wire        high_byte_mask,
	input wire [1:0]  dq_oe
);
	// ---
	// cycles since the last selected read, saturating
	// ---
	wire      rd = !cs_n && ({ras_n, cas_n, we_n} == `SDPC_CMD_RD);
	reg [3:0] rd_age;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_age <= 4'hF;
		else if (rd)
			rd_age <= 4'h0;
		else if (rd_age != 4'hF)
			rd_age <= rd_age + 4'h1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ---
	// properties
	// ---
	chk_ready_lat: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_sel: assert property (pready |-> psel && penable)
		else $error("pready outside an access");
	chk_err_decode: assert property (pready |->
		pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}))
		else $error("pslverr wrong for address");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside answer");
	// mask travels with its beat: two or three edges before the drive
	chk_oe_low: assert property (dq_oe[0] |-> !$past(low_byte_mask, 2) ||
		!$past(low_byte_mask, 3))
		else $error("low byte driven while masked");
	chk_oe_high: assert property (dq_oe[1] |-> !$past(high_byte_mask, 2) ||
		!$past(high_byte_mask, 3))
		else $error("high byte driven while masked");
	chk_oe_start: assert property ($rose(|dq_oe) |-> $past(rd, 2) || $past(rd, 3))
		else $error("read data not at two or three clocks");
	chk_oe_stale: assert property (rd_age > 4'hB |-> dq_oe == 2'b00)
		else $error("data driven with no selected read");
	cov_read: cover property (dq_oe == 2'b11);
	cov_part: cover property (dq_oe == 2'b01);
	cov_err: cover property (pready && pslverr);
endmodule // sdpc_core_assertions
`default_nettype wire

/* dv/sdpc_ctl_model.sv */
// memory controller model driving the sdram command, address and data pins
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_map.vh"
module sdpc_ctl_model (
	input  wire             pclk,
	output var logic        cs_n,
	output var logic        ras_n,
	output var logic        cas_n,
	output var logic        we_n,
	output var logic [11:0] addr,
	output var logic        cke,
	output var logic        low_byte_mask,
	output var logic        high_byte_mask,
	output var logic [15:0] dq_in
);
	initial begin
		{cs_n, ras_n, cas_n, we_n, cke, high_byte_mask, low_byte_mask} = 7'h7B;
		{addr, dq_in} = 28'h0;
	end
	// one command cycle, then deselect with address and data inverted
	task cmd(input [2:0] c, input [11:0] a, input [15:0] d, input [1:0] m, input s);
		@(posedge pclk);
		cs_n <= s;
		{ras_n, cas_n, we_n} <= c;
		addr <= a;
		dq_in <= d;
		{high_byte_mask, low_byte_mask} <= m;
		@(posedge pclk);
		cs_n <= 1'b1;
		{ras_n, cas_n, we_n} <= `SDPC_CMD_NOP;
		addr <= ~a;
		dq_in <= ~d;
	endtask
	task gate(input v);
		@(posedge pclk);
		cke <= v;
		repeat (5) @(posedge pclk);
	endtask
endmodule // sdpc_ctl_model
`default_nettype wire

/* dv/sdram_pin_command_interface_test.sv */
// self-checking bench for the sdram pin interface
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_map.vh"
module sdram_pin_command_interface_test;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
	logic        cs_n, ras_n, cas_n, we_n, cke, low_byte_mask, high_byte_mask;
	logic [11:0] paddr, addr, mc;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] dq_in, dq_out, d, x;
	logic [1:0]  dq_oe;
	integer      seed, miscompares, n_checks, cl, i, k;
	int          mem[256];
	sdpc_core u_dut (.*);
	sdpc_ctl_model u_ctl (.*);
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ---
	// tasks
	// ---
	task chk(input [31:0] x_exp, input [31:0] x_got, input string nm);
		n_checks++;
		if (x_got !== x_exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x_exp, x_got);
		end
	endtask
	task give_verdict;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task apb(input w, input [11:0] a, input [31:0] wd);
		integer n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			miscompares++;
			give_verdict;
		end
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rr(input [11:0] a, input [31:0] x_exp);
		apb(1'b0, a, 32'h0);
		chk(x_exp, q, "register");
	endtask
	task step(input [2:0] c, input [11:0] a, input [31:0] s_exp);
		u_ctl.cmd(c, a, 16'h0, 2'b00, 1'b0);
		rr(`SDPC_OFS_STATUS, s_exp);
	endtask
	task wr(input [7:0] c, input [1:0] mk, input s);
		d = 16'($random(seed));
		u_ctl.cmd(`SDPC_CMD_WR, {4'h0, c}, d, mk, s);
		if (!s) mem[c] = {mk[1] ? mem[c][15:8] : d[15:8], mk[0] ? mem[c][7:0] : d[7:0]};
	endtask
	task rd(input [7:0] c, input [1:0] mk, input ap);
		u_ctl.cmd(`SDPC_CMD_RD, {1'b0, ap, 2'b00, c}, 16'h0, mk, 1'b0);
		for (i = 1; i < cl; i++) begin
			@(negedge pclk);
			chk(0, dq_oe, "early drive");
			@(posedge pclk);
		end
		@(negedge pclk);
		x = {{8{!mk[1]}}, {8{!mk[0]}}};
		chk({~mk, mem[c][15:0] & x}, {dq_oe, dq_out & x}, "read");
	endtask
	// ---
	// main sequence
	// ---
	initial begin
		seed = 32'h036B091E;
		{miscompares, n_checks} = 64'h0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
		ce = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rr(`SDPC_OFS_CTRL, 32'h1);
		rr(`SDPC_OFS_MODE, `SDPC_MODE_RESET);
		apb(1'b0, 12'h014, 32'h0);
		chk(1, e, "unmapped");
		u_ctl.gate(1'b1);
		rr(`SDPC_OFS_STATUS, 32'h81);
		$display("reset test done");
		step(`SDPC_CMD_ACT, 12'hDA5, 32'hC1);
		step(`SDPC_CMD_ACT, 12'h7FF, 32'hE1);
		rr(`SDPC_OFS_ROW0, 32'h7FF);
		rr(`SDPC_OFS_ROW1, 32'h5A5);
		wr(8'hC3, 2'b00, 1'b0);
		wr(8'hC3, 2'b01, 1'b0);
		wr(8'hC3, 2'b00, 1'b1);
		for (k = 2; k <= 3; k++) begin
			cl = 5 - k;
			mc = 12'(12'h800 | cl << 4);
			u_ctl.cmd(`SDPC_CMD_MRS, mc, 16'h0, 2'b00, 1'b0);
			rr(`SDPC_OFS_MODE, mc);
			rd(8'hC3, k == 2 ? 2'b10 : 2'b01, 1'b0);
		end
		rd(8'hC3, 2'b00, 1'b1);
		rr(`SDPC_OFS_STATUS, 32'hC1);
		// two-beat sequential burst, latency two
		u_ctl.cmd(`SDPC_CMD_MRS, 12'h021, 16'h0, 2'b00, 1'b0);
		wr(8'hC4, 2'b00, 1'b0);
		mem[8'hC5] = {16'h0, ~d};
		rd(8'hC4, 2'b00, 1'b0);
		@(negedge pclk);
		chk({2'b11, mem[8'hC5][15:0]}, {dq_oe, dq_out}, "burst beat");
		$display("data test done");
		step(`SDPC_CMD_ACT, 12'h123, 32'hE1);
		step(`SDPC_CMD_PRE, 12'h800, 32'hA1);
		step(`SDPC_CMD_ACT, 12'h9AB, 32'hE1);
		step(`SDPC_CMD_PRE, 12'h400, 32'h81);
		u_ctl.gate(1'b0);
		rr(`SDPC_OFS_STATUS, 32'h02);
		u_ctl.gate(1'b1);
		u_ctl.cmd(`SDPC_CMD_REF, 12'h0, 16'h0, 2'b00, 1'b0);
		u_ctl.gate(1'b0);
		rr(`SDPC_OFS_STATUS, 32'h08);
		u_ctl.cmd(`SDPC_CMD_ACT, 12'h0AA, 16'h0, 2'b00, 1'b0);
		u_ctl.gate(1'b1);
		rr(`SDPC_OFS_STATUS, 32'h81);
		$display("bank and gate test done");
		// command enable cleared, then clock enable low: both ignore an activate
		apb(1'b1, `SDPC_OFS_CTRL, 32'h0);
		rr(`SDPC_OFS_CTRL, 32'h0);
		step(`SDPC_CMD_ACT, 12'h0AA, 32'h81);
		apb(1'b1, `SDPC_OFS_CTRL, 32'h1);
		rr(`SDPC_OFS_CTRL, 32'h1);
		@(posedge pclk);
		ce <= 1'b0;
		u_ctl.cmd(`SDPC_CMD_ACT, 12'h0AA, 16'h0, 2'b00, 1'b0);
		ce <= 1'b1;
		rr(`SDPC_OFS_STATUS, 32'h81);
		$display("enable test done");
		give_verdict;
	end
endmodule // sdram_pin_command_interface_test
bind sdpc_core sdpc_core_assertions u_chk (.*);
`default_nettype wire
